// file: rtl/stp_regs.vh
// Register map, field positions and timing constants of the shared timer prescaler
`ifndef STP_REGS_VH
`define STP_REGS_VH

// ==================================================================
// Register addresses (data space and short I/O space)
`define STP_ADDR_W 8
`define STP_CTRL_DATA_ADDR 8'h43
`define STP_IO_OFFSET 8'h20
`define STP_CTRL_IO_ADDR 8'h23
`define STP_CTRL_RESET 8'h00

// ==================================================================
// Control register fields
`define STP_BIT_HOLD 7
`define STP_BIT_ASYNC_RST 1
`define STP_BIT_SHARED_RST 0

// ==================================================================
// Clock source selection codes
`define STP_SEL_W 3
`define STP_SEL_STOP 3'h0
`define STP_SEL_SYS 3'h1
`define STP_SEL_DIV8 3'h2
`define STP_SEL_DIV64 3'h3
`define STP_SEL_DIV256 3'h4
`define STP_SEL_DIV1024 3'h5
`define STP_SEL_EXT_FALL 3'h6
`define STP_SEL_EXT_RISE 3'h7

// ==================================================================
// Prescaler counter and tap wrap masks
`define STP_PRE_W 10
`define STP_PRE_ZERO 10'h000
`define STP_PRE_ONE 10'h001
`define STP_MASK8 10'h007
`define STP_MASK64 10'h03f
`define STP_MASK256 10'h0ff
`define STP_MASK1024 10'h3ff

`endif

// file: rtl/stp_pin_sync.v
// External count pin synchronizer and edge detector
`timescale 1ns/100ps
`default_nettype none

module stp_pin_sync (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Raw pin
  input wire pin_in,
  // Detected edges, one cycle each
  output reg rise_pulse,
  output reg fall_pulse
);

  // ==================================================================
  // Front end: falling-edge register, then two rising-edge flops
  reg pin_latch;
  reg sync_a;
  reg sync_b;

  // The latch closes at the falling edge and holds through the low phase,
  // so the rising-edge flop always sees the pin as it stood at that fall
  always @(negedge sys_clk) begin
    pin_latch <= pin_in;
  end

  // Two rising-edge stages; reset loads the pin level so no false edge follows it
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= pin_latch;
      sync_b <= pin_latch;
    end else begin
      sync_a <= pin_latch;
      sync_b <= sync_a;
    end
  end

  // ==================================================================
  // Edge detector; a further agreeing stage would push the pin-to-count delay past 3.5 cycles
  always @* begin
    rise_pulse = sync_a && !sync_b;
    fall_pulse = !sync_a && sync_b;
  end

endmodule
`default_nettype wire

// file: rtl/stp_prescaler.v
// Shared prescaler, clock source select and timer sync control register
`timescale 1ns/100ps
`default_nettype none
`include "stp_regs.vh"

module stp_prescaler (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port: data-space and short I/O accesses
  input wire [`STP_ADDR_W-1:0] reg_addr,
  input wire reg_io_space,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Clock source selections from the two timers
  input wire [`STP_SEL_W-1:0] timer_a_clk_source_sel,
  input wire [`STP_SEL_W-1:0] timer_b_clk_source_sel,
  // External count pins
  input wire timer_a_ext_count_pin,
  input wire timer_b_ext_count_pin,
  // Asynchronous timer prescaler handshake
  input wire async_mode,
  input wire async_reset_done,
  output reg async_prescaler_reset_out,
  // Tick outputs to the timers
  output reg timer_a_tick,
  output reg timer_b_tick
);

  // ==================================================================
  // Address decode, used for both reads and writes
  function addr_hit;
    input [`STP_ADDR_W-1:0] addr;
    input io_space;
    begin
      addr_hit = io_space ? (addr == `STP_CTRL_IO_ADDR) : (addr == `STP_CTRL_DATA_ADDR);
    end
  endfunction

  wire ctrl_wr = reg_wr && addr_hit(reg_addr, reg_io_space);
  wire ctrl_rd = reg_rd && addr_hit(reg_addr, reg_io_space);

  // ==================================================================
  // Control register
  reg sync_hold_mode;
  reg async_prescaler_reset;
  reg shared_prescaler_reset;
  reg next_async;
  reg next_shared;
  reg next_hold;

  // Reset bits persist only under hold; async bit waits for its domain
  always @* begin
    next_hold = sync_hold_mode;
    next_async = async_prescaler_reset;
    next_shared = shared_prescaler_reset;
    if (ctrl_wr) begin
      next_hold = reg_wdata[`STP_BIT_HOLD];
      next_async = async_prescaler_reset | reg_wdata[`STP_BIT_ASYNC_RST];
      next_shared = shared_prescaler_reset | reg_wdata[`STP_BIT_SHARED_RST];
    end
    if (!next_hold) begin
      if (ctrl_wr && sync_hold_mode) begin
        next_async = 1'b0;
        next_shared = 1'b0;
      end else begin
        // A freshly written bit is applied for one cycle, then clears, except an async bit still waiting for its domain
        if (!ctrl_wr || !reg_wdata[`STP_BIT_SHARED_RST]) begin
          next_shared = 1'b0;
        end
        if ((!ctrl_wr || !reg_wdata[`STP_BIT_ASYNC_RST]) && !(async_mode && !async_reset_done)) begin
          next_async = 1'b0;
        end
      end
    end
  end

  // Reset value of the whole register, split into its fields below
  wire [7:0] ctrl_reset_val = `STP_CTRL_RESET;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      sync_hold_mode <= ctrl_reset_val[`STP_BIT_HOLD];
      async_prescaler_reset <= ctrl_reset_val[`STP_BIT_ASYNC_RST];
      shared_prescaler_reset <= ctrl_reset_val[`STP_BIT_SHARED_RST];
    end else begin
      sync_hold_mode <= next_hold;
      async_prescaler_reset <= next_async;
      shared_prescaler_reset <= next_shared;
    end
  end

  // Read data registered; unused bits read as zero
  always @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= `STP_CTRL_RESET;
    end else if (ctrl_rd) begin
      reg_rdata <= {sync_hold_mode, 5'h00, async_prescaler_reset, shared_prescaler_reset};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      async_prescaler_reset_out <= 1'b0;
    end else begin
      async_prescaler_reset_out <= next_async;
    end
  end

  // ==================================================================
  // Shared prescaler: free-running ten-bit count, held clear during reset
  reg [`STP_PRE_W-1:0] pre_count;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      pre_count <= `STP_PRE_ZERO;
    end else if (shared_prescaler_reset) begin
      pre_count <= `STP_PRE_ZERO;
    end else begin
      pre_count <= pre_count + `STP_PRE_ONE;
    end
  end

  // Tap strobes fire at each divisor wrap, shared by every timer
  wire tap8 = (pre_count & `STP_MASK8) == `STP_MASK8;
  wire tap64 = (pre_count & `STP_MASK64) == `STP_MASK64;
  wire tap256 = (pre_count & `STP_MASK256) == `STP_MASK256;
  wire tap1024 = (pre_count & `STP_MASK1024) == `STP_MASK1024;

  // ==================================================================
  // Per-timer source select; the pin path is never divided
  wire [1:0] ext_rise;
  wire [1:0] ext_fall;
  wire [`STP_SEL_W-1:0] sel [0:1];
  wire [1:0] tick_next;
  assign sel[0] = timer_a_clk_source_sel;
  assign sel[1] = timer_b_clk_source_sel;

  stp_pin_sync u_sync_a (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(timer_a_ext_count_pin),
    .rise_pulse(ext_rise[0]),
    .fall_pulse(ext_fall[0])
  );

  stp_pin_sync u_sync_b (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(timer_b_ext_count_pin),
    .rise_pulse(ext_rise[1]),
    .fall_pulse(ext_fall[1])
  );

  function pick_tick;
    input [`STP_SEL_W-1:0] s;
    input hold_off;
    input t8;
    input t64;
    input t256;
    input t1024;
    input er;
    input ef;
    begin
      case (s)
        `STP_SEL_STOP: pick_tick = 1'b0;
        `STP_SEL_SYS: pick_tick = 1'b1;
        `STP_SEL_DIV8: pick_tick = t8 && !hold_off;
        `STP_SEL_DIV64: pick_tick = t64 && !hold_off;
        `STP_SEL_DIV256: pick_tick = t256 && !hold_off;
        `STP_SEL_DIV1024: pick_tick = t1024 && !hold_off;
        `STP_SEL_EXT_FALL: pick_tick = ef;
        `STP_SEL_EXT_RISE: pick_tick = er;
        default: pick_tick = 1'b0;
      endcase
    end
  endfunction

  // Independent selection per timer, one shared counter feeding both
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sel
      assign tick_next[gi] = pick_tick(sel[gi], shared_prescaler_reset, tap8, tap64, tap256,
                                       tap1024, ext_rise[gi], ext_fall[gi]);
    end
  endgenerate

  // Registered ticks; pin path totals about three cycles
  always @(posedge sys_clk) begin
    if (!rstn) begin
      timer_a_tick <= 1'b0;
      timer_b_tick <= 1'b0;
    end else begin
      timer_a_tick <= tick_next[0];
      timer_b_tick <= tick_next[1];
    end
  end

endmodule
`default_nettype wire

// file: bench/stp_timer_model.sv
// Behavioural pair of timers that count the ticks they are handed
`timescale 1ns/100ps
`default_nettype none
module stp_timer_model (
  // Clock, reset and bench clear
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clr,
  // Ticks in, counts out
  input wire logic tick_a,
  input wire logic tick_b,
  output logic [15:0] cnt_a,
  output logic [15:0] cnt_b
);
  // One count per tick; a tick held high counts every cycle
  always @(posedge sys_clk) begin
    if (!rstn || clr) begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
    end else begin
      cnt_a <= cnt_a + {15'h0, tick_a};
      cnt_b <= cnt_b + {15'h0, tick_b};
    end
  end
endmodule
`default_nettype wire

// file: bench/stp_prescaler_monitor.sv
// Port assertions for the shared timer prescaler
`timescale 1ns/100ps
`default_nettype none
`include "stp_regs.vh"
module stp_prescaler_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Timer selections and count pins
  input wire logic [2:0] timer_a_clk_source_sel,
  input wire logic [2:0] timer_b_clk_source_sel,
  input wire logic timer_a_ext_count_pin,
  input wire logic timer_b_ext_count_pin,
  // Asynchronous prescaler handshake and ticks
  input wire logic async_mode,
  input wire logic async_reset_done,
  input wire logic async_prescaler_reset_out,
  input wire logic timer_a_tick,
  input wire logic timer_b_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Ticks follow the selection taken one edge earlier
  chk_stop_no_tick: assert property ($past(timer_a_clk_source_sel) == `STP_SEL_STOP |-> !timer_a_tick)
    else $error("tick while stopped");
  chk_sys_every_cycle: assert property ($past(rstn) && $past(timer_a_clk_source_sel) == `STP_SEL_SYS |-> timer_a_tick)
    else $error("missing system tick");
  chk_div8_gap: assert property (timer_a_tick && timer_a_clk_source_sel == `STP_SEL_DIV8 |=> !timer_a_tick [*6])
    else $error("divide by 8 tick too soon");
  // Read data stands one cycle, unmapped places read zero
  chk_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr != (reg_io_space ? `STP_CTRL_IO_ADDR : `STP_CTRL_DATA_ADDR)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Async reset bit pulses, or waits for the far prescaler
  chk_async_pulse: assert property (reg_wr && !reg_io_space && reg_addr == `STP_CTRL_DATA_ADDR && reg_wdata == 8'h02
    && !async_mode |-> ##[1:2] async_prescaler_reset_out ##1 !async_prescaler_reset_out)
    else $error("async reset not a pulse");
  chk_async_wait: assert property (async_prescaler_reset_out && async_mode && !async_reset_done
    |=> async_prescaler_reset_out)
    else $error("async reset dropped early");
  // Pin edge reaches the tick within a few cycles
  chk_pin_latency: assert property ($rose(timer_a_ext_count_pin) && timer_a_clk_source_sel == `STP_SEL_EXT_RISE
    |-> ##[2:3] timer_a_tick)
    else $error("pin tick late");
endmodule
bind stp_prescaler stp_prescaler_monitor u_monitor (.*);
`default_nettype wire

// file: bench/stp_prescaler_tb.sv
// Self-checking bench for the shared timer prescaler
`timescale 1ns/100ps
`default_nettype none
`include "stp_regs.vh"
module stp_prescaler_tb;
  // Bench copies of the ports
  logic sys_clk, rstn, wr, rd, io, mode, done, pa, pb, clr, aout, ta, tb;
  logic [7:0] addr, wd, rdat, d;
  logic [2:0] sa, sb;
  logic [15:0] ca, cb;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  stp_prescaler dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(addr), .reg_io_space(io), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .timer_a_clk_source_sel(sa), .timer_b_clk_source_sel(sb),
    .timer_a_ext_count_pin(pa), .timer_b_ext_count_pin(pb), .async_mode(mode), .async_reset_done(done),
    .async_prescaler_reset_out(aout), .timer_a_tick(ta), .timer_b_tick(tb));
  stp_timer_model model (.sys_clk(sys_clk), .rstn(rstn), .clr(clr), .tick_a(ta), .tick_b(tb),
    .cnt_a(ca), .cnt_b(cb));
  task cyc(int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task end_of_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Range compare; equal bounds make it exact, unknowns never pass
  task chk(string what, logic [15:0] lo, logic [15:0] hi, logic [15:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask
  // Register strobes span exactly one rising edge
  task wreg(logic [7:0] a, logic s, logic [7:0] v);
    cyc(1);
    addr = a;
    io = s;
    wd = v;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task rreg(logic [7:0] a, logic s);
    cyc(1);
    addr = a;
    io = s;
    rd = 1;
    cyc(1);
    rd = 0;
    d = rdat;
  endtask
  // Reset value, both spaces, hold, self-clear, unmapped place
  task s_regs();
    rreg(8'h43, 0);
    chk("reset value", 0, 0, {8'h00, d});
    wreg(8'h43, 0, 8'h81);
    rreg(8'h23, 1);
    chk("held bits", 8'h81, 8'h81, {8'h00, d});
    rreg(8'h44, 0);
    chk("unmapped", 0, 0, {8'h00, d});
    wreg(8'h23, 1, 8'h00);
    rreg(8'h43, 0);
    chk("hold off", 0, 0, {8'h00, d});
    wreg(8'h43, 0, 8'h01);
    rreg(8'h43, 0);
    chk("self clear", 0, 0, {8'h00, d});
  endtask
  // Hold freezes both timers; release restarts them in step
  task s_halt();
    wreg(8'h43, 0, 8'h81);
    sa = `STP_SEL_DIV8;
    sb = `STP_SEL_DIV8;
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(40);
    chk("halted a", 0, 0, ca);
    chk("halted b", 0, 0, cb);
    wreg(8'h43, 0, 8'h00);
    cyc(30);
    chk("in step", ca, ca, cb);
    chk("resumed", 2, 4, ca);
    sa = 0;
    sb = 0;
  endtask
  // Stop, system and the four divided sources over 2048 cycles after a prescaler reset
  task s_rates();
    logic [15:0] ea, eb;
    for (int i = 0; i < 3; i++) begin
      wreg(8'h43, 0, 8'h01);
      sa = i == 0 ? `STP_SEL_SYS : i == 1 ? `STP_SEL_DIV8 : `STP_SEL_DIV256;
      sb = i == 0 ? `STP_SEL_STOP : i == 1 ? `STP_SEL_DIV64 : `STP_SEL_DIV1024;
      ea = i == 0 ? 16'd2048 : i == 1 ? 16'd256 : 16'd8;
      eb = i == 0 ? 16'd0 : i == 1 ? 16'd32 : 16'd2;
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(2048);
      chk("count a", ea - 1, ea + 1, ca);
      chk("count b", eb - (eb != 0), eb + (eb != 0), cb);
      sa = 0;
      sb = 0;
    end
  endtask
  // Tap enabled at an arbitrary phase
  task s_first();
    for (int k = 0; k < 2; k++) begin
      cyc(5);
      sa = k == 0 ? `STP_SEL_DIV8 : `STP_SEL_DIV64;
      for (n = 0; n < 80 && ta !== 1'b1; n++) cyc(1);
      chk("first tick", 1, k == 0 ? 16'd9 : 16'd65, n[15:0]);
      sa = 0;
    end
  endtask
  // Ten six-cycle pin periods, one polarity per timer
  task s_ext();
    sa = `STP_SEL_EXT_RISE;
    sb = `STP_SEL_EXT_FALL;
    clr = 1;
    cyc(1);
    clr = 0;
    // Pins move by non-blocking assignment: the latch stage takes the new level at the next falling edge
    repeat (10) begin
      cyc(3);
      pa <= 1;
      pb <= 1;
      cyc(3);
      pa <= 0;
      pb <= 0;
    end
    cyc(6);
    chk("rise ticks", 10, 10, ca);
    chk("fall ticks", 10, 10, cb);
    sa = 0;
    sb = 0;
  endtask
  // Async reset bit: pulse, then held until the far side is done
  task s_async();
    wreg(8'h43, 0, 8'h02);
    chk("async set", 1, 1, {15'h0, aout});
    cyc(3);
    chk("async pulse", 0, 0, {15'h0, aout});
    mode = 1;
    wreg(8'h43, 0, 8'h02);
    cyc(5);
    chk("async held", 1, 1, {15'h0, aout});
    rreg(8'h43, 0);
    chk("async bit read", 8'h02, 8'h02, {8'h00, d});
    done = 1;
    cyc(3);
    chk("async freed", 0, 0, {15'h0, aout});
    mode = 0;
    done = 0;
  endtask
  // 200 MHz clock
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    {rstn, wr, rd, io, mode, done, pa, pb, clr} = 9'h000;
    {addr, wd, sa, sb} = 22'h0;
    cyc(16);
    rstn = 1;
    s_regs();
    s_halt();
    s_rates();
    s_first();
    s_ext();
    s_async();
    end_of_test();
  end
  // Watchdog: the run needs about 6400 cycles
  initial begin
    #100us;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
